// *** dpl_limit_regs.sv ***
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module dpl_limit_regs (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [dpl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [dpl_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [dpl_pkg::DATA_W-1:0] reg_rdata,
    input wire logic signed [dpl_pkg::OFFS_W-1:0] main_equipment_loop_offs,
    input wire logic signed [dpl_pkg::OFFS_W-1:0] aux_bits_loop_offs,
    output logic [dpl_pkg::BOUND_W-1:0] loop_freq_bound,
    output logic signed [dpl_pkg::OFFS_W-1:0] main_equipment_loop_clamped,
    output logic signed [dpl_pkg::OFFS_W-1:0] aux_bits_loop_clamped
);
    logic [7:0] low_reg;
    logic [7:0] low_next;
    logic [1:0] high_reg;
    logic [1:0] high_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [dpl_pkg::BOUND_W-1:0] bound_reg;
    logic [dpl_pkg::BOUND_W-1:0] bound_next;
    logic signed [dpl_pkg::OFFS_W-1:0] offs_in [2];
    logic signed [dpl_pkg::OFFS_W-1:0] clamp_reg [2];
    logic signed [dpl_pkg::OFFS_W-1:0] clamp_next [2];
    logic signed [dpl_pkg::OFFS_W-1:0] pos_lim;
    logic signed [dpl_pkg::OFFS_W-1:0] neg_lim;

    always_comb begin
        low_next = low_reg;
        high_next = high_reg;
        rdata_next = 8'h00;
        if (reg_wr && reg_addr == dpl_pkg::LIMIT_LOW_ADDR) begin
            low_next = reg_wdata;
        end
        if (reg_wr && reg_addr == dpl_pkg::LIMIT_HIGH_ADDR) begin
            high_next = reg_wdata[dpl_pkg::HIGH_MSB:dpl_pkg::HIGH_LSB];
        end
        if (reg_rd) begin
            if (reg_addr == dpl_pkg::LIMIT_LOW_ADDR) begin
                rdata_next = low_reg;
            end else if (reg_addr == dpl_pkg::LIMIT_HIGH_ADDR) begin
                rdata_next = {6'h00, high_reg};
            end
        end
        bound_next = {high_reg, low_reg};
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            low_reg <= dpl_pkg::LIMIT_LOW_RST;
            high_reg <= dpl_pkg::LIMIT_HIGH_RST;
            rdata_reg <= 8'h00;
            bound_reg <= {dpl_pkg::LIMIT_HIGH_RST, dpl_pkg::LIMIT_LOW_RST};
        end else begin
            low_reg <= low_next;
            high_reg <= high_next;
            rdata_reg <= rdata_next;
            bound_reg <= bound_next;
        end
    end

    assign offs_in[0] = main_equipment_loop_offs;
    assign offs_in[1] = aux_bits_loop_offs;
    assign pos_lim = $signed({6'h00, bound_reg});
    assign neg_lim = -pos_lim;

    // Same bound serves both loops
    for (genvar i = 0; i < 2; i++) begin : g_clamp
        always_comb begin
            if (offs_in[i] > pos_lim) begin
                clamp_next[i] = pos_lim;
            end else if (offs_in[i] < neg_lim) begin
                clamp_next[i] = neg_lim;
            end else begin
                clamp_next[i] = offs_in[i];
            end
        end
        always_ff @(posedge ref_clk) begin
            if (srst) begin
                clamp_reg[i] <= 16'h0000;
            end else begin
                clamp_reg[i] <= clamp_next[i];
            end
        end
    end

    assign reg_rdata = rdata_reg;
    assign loop_freq_bound = bound_reg;
    assign main_equipment_loop_clamped = clamp_reg[0];
    assign aux_bits_loop_clamped = clamp_reg[1];

    // Antecedents exclude the reset cycle, except the $past(srst) reset-value checks: reset wins over any strobe or offset there
    AST_LOW_RW: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && reg_wr && reg_addr == dpl_pkg::LIMIT_LOW_ADDR
        ##1 !srst && reg_rd && reg_addr == dpl_pkg::LIMIT_LOW_ADDR
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("low byte readback mismatch");

    AST_LOW_WR: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && reg_wr && reg_addr == dpl_pkg::LIMIT_LOW_ADDR
        |=> low_reg == $past(reg_wdata))
        else $error("low byte write not stored");

    AST_LOW_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && !(reg_wr && reg_addr == dpl_pkg::LIMIT_LOW_ADDR)
        |=> low_reg == $past(low_reg))
        else $error("low byte changed without a write");

    AST_LOW_RD: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && reg_rd && reg_addr == dpl_pkg::LIMIT_LOW_ADDR
        |=> reg_rdata == $past(low_reg))
        else $error("low byte read data wrong");

    AST_RDATA_IDLE: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && !reg_rd
        |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");

    AST_UNMAPPED_RD: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && reg_rd && reg_addr != dpl_pkg::LIMIT_LOW_ADDR
        && reg_addr != dpl_pkg::LIMIT_HIGH_ADDR
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    AST_LOW_RST: assert property (@(posedge ref_clk)
        $past(srst)
        |-> low_reg == dpl_pkg::LIMIT_LOW_RST)
        else $error("low byte reset value wrong");

    AST_BOUND_RST: assert property (@(posedge ref_clk)
        $past(srst)
        |-> loop_freq_bound == {dpl_pkg::LIMIT_HIGH_RST, dpl_pkg::LIMIT_LOW_RST})
        else $error("bound reset value wrong");

    AST_HIGH_RD: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && reg_rd && reg_addr == dpl_pkg::LIMIT_HIGH_ADDR
        |=> reg_rdata[dpl_pkg::DATA_W-1:dpl_pkg::HIGH_MSB+1] == 6'h00
        && reg_rdata[dpl_pkg::HIGH_MSB:dpl_pkg::HIGH_LSB] == $past(high_reg))
        else $error("high register readback wrong");

    AST_HIGH_WR: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && reg_wr && reg_addr == dpl_pkg::LIMIT_HIGH_ADDR
        |=> high_reg == $past(reg_wdata[dpl_pkg::HIGH_MSB:dpl_pkg::HIGH_LSB]))
        else $error("high register write not stored");

    AST_HIGH_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && !(reg_wr && reg_addr == dpl_pkg::LIMIT_HIGH_ADDR)
        |=> high_reg == $past(high_reg))
        else $error("high register changed without a write");

    AST_HIGH_RST: assert property (@(posedge ref_clk)
        $past(srst)
        |-> high_reg == dpl_pkg::LIMIT_HIGH_RST)
        else $error("high register reset value wrong");

    AST_BOUND: assert property (@(posedge ref_clk) disable iff (srst)
        !srst
        |=> loop_freq_bound == {$past(high_reg), $past(low_reg)})
        else $error("bound not formed from registers");

    AST_CLAMP_MAG: assert property (@(posedge ref_clk) disable iff (srst)
        !srst
        |=> main_equipment_loop_clamped <= $past(pos_lim)
        && main_equipment_loop_clamped >= $past(neg_lim)
        && aux_bits_loop_clamped <= $past(pos_lim)
        && aux_bits_loop_clamped >= $past(neg_lim))
        else $error("clamped offset exceeds bound");

    AST_CLAMP_PASS: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && aux_bits_loop_offs <= pos_lim && aux_bits_loop_offs >= neg_lim
        |=> aux_bits_loop_clamped == $past(aux_bits_loop_offs))
        else $error("in-range offset altered");

    AST_MAIN_PASS: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && main_equipment_loop_offs <= pos_lim && main_equipment_loop_offs >= neg_lim
        |=> main_equipment_loop_clamped == $past(main_equipment_loop_offs))
        else $error("in-range main offset altered");

    AST_CLAMP_NEG: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && main_equipment_loop_offs < neg_lim
        |=> main_equipment_loop_clamped == $past(neg_lim))
        else $error("negative clamp wrong");

    AST_AUX_NEG: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && aux_bits_loop_offs < neg_lim
        |=> aux_bits_loop_clamped == $past(neg_lim))
        else $error("negative aux clamp wrong");

    AST_MAIN_POS: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && main_equipment_loop_offs > pos_lim
        |=> main_equipment_loop_clamped == $past(pos_lim))
        else $error("positive main clamp wrong");

    AST_AUX_POS: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && aux_bits_loop_offs > pos_lim
        |=> aux_bits_loop_clamped == $past(pos_lim))
        else $error("positive aux clamp wrong");

    AST_MAIN_SIGN: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && main_equipment_loop_offs < 16'sh0000
        |=> main_equipment_loop_clamped <= 16'sh0000)
        else $error("main clamp lost the sign");

    AST_AUX_SIGN: assert property (@(posedge ref_clk) disable iff (srst)
        !srst && aux_bits_loop_offs > 16'sh0000
        |=> aux_bits_loop_clamped >= 16'sh0000)
        else $error("aux clamp lost the sign");

    AST_CLAMP_RST: assert property (@(posedge ref_clk)
        $past(srst)
        |-> main_equipment_loop_clamped == 16'h0000 && aux_bits_loop_clamped == 16'h0000)
        else $error("clamped outputs not cleared by reset");

    COV_LOW_WR: cover property (@(posedge ref_clk) reg_wr && reg_addr == dpl_pkg::LIMIT_LOW_ADDR);
    COV_HIGH_WR: cover property (@(posedge ref_clk) reg_wr && reg_addr == dpl_pkg::LIMIT_HIGH_ADDR);
    COV_CLAMP_POS: cover property (@(posedge ref_clk) main_equipment_loop_offs > pos_lim);
    COV_CLAMP_NEG: cover property (@(posedge ref_clk) aux_bits_loop_offs < neg_lim);
    COV_RD_AFTER_WR: cover property (@(posedge ref_clk) !srst && reg_wr ##1 reg_rd);
endmodule : dpl_limit_regs

// *** dpl_pkg.sv ***
package dpl_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int BOUND_W = 10;
    localparam int OFFS_W = 16;
    localparam logic [7:0] LIMIT_LOW_ADDR = 8'h41;
    localparam logic [7:0] LIMIT_HIGH_ADDR = 8'h42;
    localparam logic [7:0] LIMIT_LOW_RST = 8'h76;
    localparam logic [1:0] LIMIT_HIGH_RST = 2'h0;
    localparam int HIGH_LSB = 0;
    localparam int HIGH_MSB = 1;
endpackage : dpl_pkg

// *** dpl_limit_regs_test.sv ***
`timescale 1ns/1ps
module dpl_limit_regs_test;
    logic ref_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
    logic signed [15:0] m_offs = 16'h0000, a_offs = 16'h0000, m_clmp, a_clmp;
    logic [9:0] bound;
    int err_count = 0, compares = 0, lo = 118, hi = 0, i;
    int exp_q[$];
    logic [31:0] seed = 32'h0000B0E9;
    always #4 ref_clk = ~ref_clk;
    dpl_limit_regs dut_u (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .main_equipment_loop_offs(m_offs), .aux_bits_loop_offs(a_offs),
        .loop_freq_bound(bound), .main_equipment_loop_clamped(m_clmp),
        .aux_bits_loop_clamped(a_clmp));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk_rd(logic [7:0] e, logic [7:0] s);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("BAD rdata exp %h got %h", e, s);
        end
    endtask : chk_rd
    task automatic chk_bound(logic [9:0] e, logic [9:0] s);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("BAD bound exp %h got %h", e, s);
        end
    endtask : chk_bound
    task automatic chk_clamp(string n, logic [15:0] e, logic [15:0] s);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk_clamp
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(int'(e));
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk_rd(8'(exp_q.pop_front()), reg_rdata);
    endtask : rd
    // Expected clamp from the model bound, same limit both signs and both loops
    task automatic clamp(int m, int a);
        int b;
        b = hi * 256 + lo;
        repeat (3) @(posedge ref_clk);
        m_offs <= 16'(m);
        a_offs <= 16'(a);
        @(posedge ref_clk);
        #1 chk_bound(10'(b), bound);
        chk_clamp("main", 16'(m > b ? b : (m < -b ? -b : m)), m_clmp);
        chk_clamp("aux", 16'(a > b ? b : (a < -b ? -b : a)), a_clmp);
    endtask : clamp
    task automatic give_verdict();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        rd(8'h41, 8'h76);
        rd(8'h42, 8'h00);
        clamp(1000, -1000);
        $display("reset test done");
        for (i = 0; i < 24; i++) begin
            lo = rnd() & 255;
            d = 8'(rnd());
            hi = d & 3;
            wr(8'h41, 8'(lo));
            wr(8'h42, d);
            rd(8'h42, {6'h00, d[1:0]});
            rd(8'h41, 8'(lo));
            clamp(int'(rnd() % 2400) - 1200, int'(rnd() % 2400) - 1200);
            clamp(hi * 256 + lo, -(hi * 256 + lo) - 1);
        end
        $display("random test done");
        wr(8'h43, 8'hFF);
        rd(8'h43, 8'h00);
        rd(8'h41, 8'(lo));
        $display("unmapped test done");
        // Reset in mid-run with nonzero offsets applied must restore the defaults
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        lo = 118;
        hi = 0;
        rd(8'h41, 8'h76);
        rd(8'h42, 8'h00);
        clamp(-1000, 1000);
        $display("mid reset test done");
        give_verdict();
    end
    initial begin
        #200000;
        err_count++;
        give_verdict();
    end
endmodule : dpl_limit_regs_test
